// ---- src/spc_defines.vh ----
// How it works
// - Selector 000 idle, 001 noise, 010 down, 011 save, 110/111 standby.
// - Sleep instruction only sleeps while the sleep-allow bit is one.
// - Enabled interrupt wake holds core four cycles after start-up.
// - Power-down stops every generated clock; asynchronous wake sources remain.
// - Power-save equals power-down except an enabled timer 2 keeps counting.
// - Timer 2 wakes power-save only with its enable and global enable set.
// - Power-save stops unused timer-2 clock source; sync clock feeds only timer 2.
// - Code 110 with crystal is power-down with oscillator on, six-cycle wake.
// - Code 111 with crystal is power-save with oscillator on, six-cycle wake.
// - Set gating bit stops peripheral clock and blocks its register access.
// - Cleared gating bit resumes the peripheral in its frozen state.
// - Peripheral gating matters only in active and idle modes.
// - ADC stays enabled in sleep; re-enable makes next conversion extended.
// - Comparator auto-off in deep sleeps unless it uses internal reference.
// - Fuse-enabled brown-out detector stays active in every sleep mode.
// - Enabled watchdog stays active in every sleep mode.
// - Internal reference on only while brown-out, comparator or ADC needs it.
// - Digital input buffers off when I/O and converter clocks both stop.
// - Debug enabled by fuse keeps the main clock source in every sleep.
// - Debug disabled by either fuse unprogrammed or test-port-disable bit.
// - Sleep control register at data offset 0x53, short I/O address 0x33.
// - Extended space from 0x60 reachable only by data-space accesses.
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH

`define SPC_SLEEP_CTRL_ADDR 8'h53
`define SPC_CLK_GATE_ADDR   8'h64
`define SPC_IO_OFFSET       8'h20
`define SPC_EXT_IO_BASE     8'h60
`define SPC_SLEEP_CTRL_RST  8'h00
`define SPC_CLK_GATE_RST    8'h00
`define SPC_SEL_MSB         3
`define SPC_SEL_LSB         1
`define SPC_ALLOW_BIT       0
`define SPC_T2_GATE_BIT     6

`define SPC_MODE_IDLE       3'h0
`define SPC_MODE_NOISE      3'h1
`define SPC_MODE_DOWN       3'h2
`define SPC_MODE_SAVE       3'h3
`define SPC_MODE_STANDBY    3'h6
`define SPC_MODE_EXT_STBY   3'h7

`define SPC_STBY_WAKE_CYC   8'h06
`define SPC_HOLD_CYC        8'h04
`define SPC_STARTUP_CYC     8'h10

`endif

// ---- src/spc_sync2.v ----
`timescale 1ns/100ps
module spc_sync2 (
  // Clock and control
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_ce,
  // Data
  input  wire i_async,
  output reg  o_sync
);
  reg meta;

  always @(posedge i_clk) begin
    if (i_rst) begin
      meta   <= 1'b0;
      o_sync <= 1'b0;
    end else if (i_ce) begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule // spc_sync2

// ---- src/spc_top.v ----
`timescale 1ns/100ps
`include "spc_defines.vh"
module spc_top #(
  parameter [7:0] STARTUP_CYC = `SPC_STARTUP_CYC
) (
  // Clock, reset, enable
  input  wire       I_CORE_CLK,
  input  wire       I_RST,
  input  wire       I_CLK_EN,
  // Core register access
  input  wire       I_IO_SPACE,
  input  wire [7:0] I_ADDR,
  input  wire       I_WR,
  input  wire       I_RD,
  input  wire [7:0] I_WDATA,
  output reg  [7:0] O_RDATA,
  // Core sleep handshake
  input  wire       I_SLEEP_INSTR,
  input  wire       I_IRQ_ANY,
  input  wire       I_IRQ_NOISE,
  input  wire       I_GLOBAL_IE,
  output reg        O_CORE_HALT,
  output reg        O_SLEEPING,
  // Asynchronous wake pins
  input  wire       I_WAKE_PIN,
  // Timer 2
  input  wire       I_T2_ENABLED,
  input  wire       I_T2_ASYNC,
  input  wire       I_T2_OVF,
  input  wire       I_T2_CMP,
  input  wire [1:0] I_T2_IRQ_ENABLES,
  // Configuration and analog status
  input  wire       I_EXT_CRYSTAL,
  input  wire       I_BROWNOUT_FUSE,
  input  wire       I_WATCHDOG_ON,
  input  wire       I_DEBUG_FUSE,
  input  wire       I_TEST_PORT_FUSE,
  input  wire       I_TEST_PORT_DISABLE,
  input  wire       I_ADC_ENABLE,
  input  wire       I_ADC_CONV_START,
  input  wire       I_COMP_ENABLE,
  input  wire       I_COMP_USES_VREF,
  // Clock enables
  output reg        O_CPU_CLK_EN,
  output reg        O_FLASH_CLK_EN,
  output reg        O_IO_CLK_EN,
  output reg        O_ADC_CLK_EN,
  output reg        O_ASY_CLK_EN,
  output reg        O_MAIN_OSC_EN,
  output reg        O_TIMER_OSC_EN,
  output reg        O_T2_CLK_EN,
  output reg  [7:0] O_PERIPH_CLK_EN,
  output reg  [7:0] O_PERIPH_ACCESS_EN,
  // Analog and system controls
  output reg        O_ADC_EN,
  output reg        O_ADC_EXTENDED,
  output reg        O_COMP_OFF,
  output reg        O_VREF_EN,
  output reg        O_INPUT_BUF_EN,
  output reg        O_BROWNOUT_EN,
  output reg        O_WATCHDOG_EN,
  output reg        O_DEBUG_EN
);

  // ****************************************
  // Registers and access decode
  // ****************************************
  localparam ST_RUN   = 2'd0;
  localparam ST_SLEEP = 2'd1;
  localparam ST_START = 2'd2;
  localparam ST_HOLD  = 2'd3;
  localparam [7:0] CTRL_RST = `SPC_SLEEP_CTRL_RST;

  reg  [1:0] state;
  reg  [1:0] next_state;
  reg  [3:0] sleep_mode_control;
  reg  [7:0] peripheral_clock_gate;
  reg  [2:0] mode;
  reg        adc_was_off;
  reg        timer_load;
  reg  [7:0] timer_count;
  wire       wake_pin;
  wire       timer_busy;
  wire       timer_done;
  wire [7:0] data_addr;
  wire       hit_ctrl;
  wire       hit_gate;

  // Short I/O addresses are shifted into data space; six address bits
  // can never reach the extended space, so gating stays data-space only.
  assign data_addr = I_IO_SPACE ? ({2'b00, I_ADDR[5:0]} + `SPC_IO_OFFSET) : I_ADDR;
  assign hit_ctrl  = (data_addr == `SPC_SLEEP_CTRL_ADDR);
  assign hit_gate  = !I_IO_SPACE && (data_addr == `SPC_CLK_GATE_ADDR);

  function is_legal;
    input [2:0] sel;
    begin
      is_legal = (sel != 3'h4) && (sel != 3'h5);
    end
  endfunction

  // Standby codes fall back to the plain deep modes without a crystal,
  // since the oscillator would gain nothing kept running.
  function [2:0] effective_mode;
    input [2:0] sel;
    input       xtal;
    begin
      case (sel)
        `SPC_MODE_STANDBY:  effective_mode = xtal ? sel : `SPC_MODE_DOWN;
        `SPC_MODE_EXT_STBY: effective_mode = xtal ? sel : `SPC_MODE_SAVE;
        default:            effective_mode = sel;
      endcase
    end
  endfunction

  spc_sync2 u_wake_sync (
    .i_clk   (I_CORE_CLK),
    .i_rst   (I_RST),
    .i_ce    (I_CLK_EN),
    .i_async (I_WAKE_PIN),
    .o_sync  (wake_pin)
  );

  spc_wake_timer u_timer (
    .i_clk   (I_CORE_CLK),
    .i_rst   (I_RST),
    .i_ce    (I_CLK_EN),
    .i_load  (timer_load),
    .i_count (timer_count),
    .o_busy  (timer_busy),
    .o_done  (timer_done)
  );

  always @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sleep_mode_control    <= CTRL_RST[3:0];
      peripheral_clock_gate <= `SPC_CLK_GATE_RST;
      O_RDATA               <= 8'h00;
    end else if (I_CLK_EN) begin
      if (I_WR && hit_ctrl) begin
        sleep_mode_control <= I_WDATA[3:0];
      end
      if (I_WR && hit_gate) begin
        peripheral_clock_gate <= I_WDATA;
      end
      if (I_RD && hit_ctrl) begin
        O_RDATA <= {4'h0, sleep_mode_control};
      end else if (I_RD && hit_gate) begin
        O_RDATA <= peripheral_clock_gate;
      end else if (I_RD) begin
        O_RDATA <= 8'h00;
      end
    end
  end

  // ****************************************
  // Wake detection
  // ****************************************
  reg  t2_wake;
  reg  wake;

  always @* begin
    t2_wake = I_GLOBAL_IE && ((I_T2_OVF && I_T2_IRQ_ENABLES[0]) ||
              (I_T2_CMP && I_T2_IRQ_ENABLES[1])) && I_T2_ENABLED;
    case (mode)
      `SPC_MODE_IDLE:     wake = wake_pin || I_IRQ_ANY;
      `SPC_MODE_NOISE:    wake = wake_pin || I_IRQ_NOISE || (t2_wake && I_T2_ASYNC);
      `SPC_MODE_SAVE:     wake = wake_pin || t2_wake;
      `SPC_MODE_EXT_STBY: wake = wake_pin || t2_wake;
      default:            wake = wake_pin;
    endcase
  end

  // ****************************************
  // Sleep sequencer
  // ****************************************
  always @* begin
    next_state  = state;
    timer_load  = 1'b0;
    timer_count = 8'h00;
    case (state)
      ST_RUN: begin
        if (I_SLEEP_INSTR && sleep_mode_control[`SPC_ALLOW_BIT] &&
            is_legal(sleep_mode_control[`SPC_SEL_MSB:`SPC_SEL_LSB])) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          timer_load = 1'b1;
          case (mode)
            `SPC_MODE_IDLE, `SPC_MODE_NOISE: begin
              next_state  = ST_HOLD;
              timer_count = `SPC_HOLD_CYC;
            end
            `SPC_MODE_STANDBY, `SPC_MODE_EXT_STBY: begin
              next_state  = ST_START;
              timer_count = `SPC_STBY_WAKE_CYC;
            end
            default: begin
              next_state  = ST_START;
              timer_count = STARTUP_CYC;
            end
          endcase
        end
      end
      ST_START: begin
        if (timer_done) begin
          next_state  = ST_HOLD;
          timer_load  = 1'b1;
          timer_count = `SPC_HOLD_CYC;
        end
      end
      ST_HOLD: begin
        if (timer_done) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      state <= ST_RUN;
      mode  <= `SPC_MODE_IDLE;
    end else if (I_CLK_EN) begin
      state <= next_state;
      if (state == ST_RUN && next_state == ST_SLEEP) begin
        mode <= effective_mode(sleep_mode_control[`SPC_SEL_MSB:`SPC_SEL_LSB],
                               I_EXT_CRYSTAL);
      end
    end
  end

  // ****************************************
  // Clock and analog control
  // ****************************************
  reg       asleep;
  reg [2:0] ctl_mode;
  reg       n_cpu;
  reg       n_io;
  reg       n_adc;
  reg       n_asy;
  reg       n_main;
  reg       n_tosc;
  reg       n_t2;
  reg       n_debug;
  reg       n_comp_off;
  reg [7:0] n_periph;

  always @* begin
    // Enables follow the next state so they switch together with O_SLEEPING;
    // on entry the mode register still holds the old mode, so decode it here.
    asleep   = (next_state == ST_SLEEP) || (next_state == ST_START);
    ctl_mode = mode;
    if (state == ST_RUN) begin
      ctl_mode = effective_mode(sleep_mode_control[`SPC_SEL_MSB:`SPC_SEL_LSB], I_EXT_CRYSTAL);
    end
    n_debug = I_DEBUG_FUSE && I_TEST_PORT_FUSE && !I_TEST_PORT_DISABLE;
    n_cpu   = !asleep;
    n_io    = 1'b1;
    n_adc   = 1'b1;
    n_asy   = I_T2_ASYNC;
    n_main  = 1'b1;
    n_tosc  = I_T2_ASYNC;
    n_t2    = 1'b1;
    if (asleep) begin
      case (ctl_mode)
        `SPC_MODE_IDLE: begin
          n_io = 1'b1;
        end
        `SPC_MODE_NOISE: begin
          n_io = 1'b0;
          n_t2 = I_T2_ASYNC;
        end
        `SPC_MODE_SAVE, `SPC_MODE_EXT_STBY: begin
          n_io   = 1'b0;
          n_adc  = 1'b0;
          n_asy  = I_T2_ENABLED && I_T2_ASYNC;
          n_tosc = I_T2_ENABLED && I_T2_ASYNC;
          n_t2   = I_T2_ENABLED;
          n_main = (ctl_mode == `SPC_MODE_EXT_STBY) ||
                   (I_T2_ENABLED && !I_T2_ASYNC);
        end
        `SPC_MODE_STANDBY: begin
          n_io   = 1'b0;
          n_adc  = 1'b0;
          n_asy  = 1'b0;
          n_tosc = 1'b0;
          n_t2   = 1'b0;
          n_main = 1'b1;
        end
        default: begin
          n_io   = 1'b0;
          n_adc  = 1'b0;
          n_asy  = 1'b0;
          n_tosc = 1'b0;
          n_t2   = 1'b0;
          n_main = 1'b0;
        end
      endcase
      if (n_debug) begin
        n_main = 1'b1;
      end
    end
    // Gating only acts while the I/O clock runs; deeper modes stop it anyway.
    n_periph   = n_io ? ~peripheral_clock_gate : 8'h00;
    n_comp_off = asleep && (ctl_mode != `SPC_MODE_IDLE) && (ctl_mode != `SPC_MODE_NOISE) &&
                 !I_COMP_USES_VREF;
  end

  always @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_CORE_HALT        <= 1'b0;
      O_SLEEPING         <= 1'b0;
      O_CPU_CLK_EN       <= 1'b1;
      O_FLASH_CLK_EN     <= 1'b1;
      O_IO_CLK_EN        <= 1'b1;
      O_ADC_CLK_EN       <= 1'b1;
      O_ASY_CLK_EN       <= 1'b0;
      O_MAIN_OSC_EN      <= 1'b1;
      O_TIMER_OSC_EN     <= 1'b0;
      O_T2_CLK_EN        <= 1'b1;
      O_PERIPH_CLK_EN    <= 8'hFF;
      O_PERIPH_ACCESS_EN <= 8'hFF;
      O_ADC_EN           <= 1'b0;
      O_ADC_EXTENDED     <= 1'b1;
      adc_was_off        <= 1'b1;
      O_COMP_OFF         <= 1'b0;
      O_VREF_EN          <= 1'b0;
      O_INPUT_BUF_EN     <= 1'b1;
      O_BROWNOUT_EN      <= 1'b0;
      O_WATCHDOG_EN      <= 1'b0;
      O_DEBUG_EN         <= 1'b0;
    end else if (I_CLK_EN) begin
      O_CORE_HALT        <= (next_state != ST_RUN);
      O_SLEEPING         <= (next_state == ST_SLEEP) || (next_state == ST_START);
      O_CPU_CLK_EN       <= n_cpu;
      O_FLASH_CLK_EN     <= n_cpu;
      O_IO_CLK_EN        <= n_io;
      O_ADC_CLK_EN       <= n_adc;
      O_ASY_CLK_EN       <= n_asy;
      O_MAIN_OSC_EN      <= n_main;
      O_TIMER_OSC_EN     <= n_tosc;
      // In power-save an enabled timer 2 keeps its own synchronous feed; other peripherals lose it.
      O_T2_CLK_EN        <= n_t2 && !(n_io && peripheral_clock_gate[`SPC_T2_GATE_BIT]);
      O_PERIPH_CLK_EN    <= n_periph;
      O_PERIPH_ACCESS_EN <= ~peripheral_clock_gate;
      O_ADC_EN           <= I_ADC_ENABLE;
      adc_was_off        <= !I_ADC_ENABLE;
      // A fresh enable wins over a conversion start in the same cycle.
      if (I_ADC_ENABLE && adc_was_off) begin
        O_ADC_EXTENDED <= 1'b1;
      end else if (I_ADC_CONV_START) begin
        O_ADC_EXTENDED <= 1'b0;
      end
      O_COMP_OFF         <= n_comp_off;
      O_VREF_EN          <= I_BROWNOUT_FUSE || I_ADC_ENABLE ||
                            (I_COMP_ENABLE && I_COMP_USES_VREF);
      O_INPUT_BUF_EN     <= n_io || n_adc;
      O_BROWNOUT_EN      <= I_BROWNOUT_FUSE;
      O_WATCHDOG_EN      <= I_WATCHDOG_ON;
      O_DEBUG_EN         <= n_debug;
    end
  end

endmodule // spc_top

// ---- src/spc_wake_timer.v ----
`timescale 1ns/100ps
module spc_wake_timer (
  // Clock and control
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_ce,
  // Count
  input  wire       i_load,
  input  wire [7:0] i_count,
  output wire       o_busy,
  output wire       o_done
);
  reg [7:0] remain;

  assign o_busy = (remain != 8'h00);
  assign o_done = (remain == 8'h01);

  always @(posedge i_clk) begin
    if (i_rst) begin
      remain <= 8'h00;
    end else if (i_ce) begin
      if (i_load) begin
        remain <= i_count;
      end else if (remain != 8'h00) begin
        remain <= remain - 8'h01;
      end
    end
  end
endmodule // spc_wake_timer

// ---- testbench/spc_monitor.sv ----
`timescale 1ns/100ps
// ********
// Port-level checks for the sleep controller.
// ********
module spc_monitor #(
  parameter [7:0] STARTUP_CYC = 8'h10
) (
  // Clock and reset
  input wire       I_CORE_CLK,
  input wire       I_RST,
  // Register access
  input wire       I_IO_SPACE,
  input wire [7:0] I_ADDR,
  input wire       I_RD,
  input wire [7:0] O_RDATA,
  // Sleep
  input wire       I_SLEEP_INSTR,
  input wire       O_SLEEPING,
  input wire       O_CORE_HALT,
  // Controls
  input wire       I_WATCHDOG_ON,
  input wire       I_DEBUG_FUSE,
  input wire       I_TEST_PORT_FUSE,
  input wire       I_TEST_PORT_DISABLE,
  input wire       I_COMP_USES_VREF,
  // Enables
  input wire       O_IO_CLK_EN,
  input wire       O_ADC_CLK_EN,
  input wire       O_MAIN_OSC_EN,
  input wire [7:0] O_PERIPH_CLK_EN,
  input wire [7:0] O_PERIPH_ACCESS_EN,
  input wire       O_INPUT_BUF_EN,
  input wire       O_WATCHDOG_EN,
  input wire       O_DEBUG_EN,
  input wire       O_COMP_OFF
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  property p_sleep_cause;
    $rose(O_SLEEPING) |-> $past(I_SLEEP_INSTR);
  endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("sleep without instruction");

  property p_wake_hold;
    $fell(O_SLEEPING) |-> O_CORE_HALT [*4] ##1 !O_CORE_HALT;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("core hold is not four cycles");

  property p_rd_upper;
    I_RD && (I_IO_SPACE || I_ADDR != 8'h64) |=> O_RDATA[7:4] == 4'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");

  property p_gate_access;
    (O_PERIPH_CLK_EN & ~O_PERIPH_ACCESS_EN) == 8'h00;
  endproperty
  a_gate_access: assert property (p_gate_access) else $error("gated clock runs");

  property p_gate_sleep;
    !O_IO_CLK_EN |-> O_PERIPH_CLK_EN == 8'h00;
  endproperty
  a_gate_sleep: assert property (p_gate_sleep) else $error("peripheral clock in deep sleep");

  // Mirrored outputs hold reset values for one edge after release.
  property p_inbuf;
    !$past(I_RST) |-> O_INPUT_BUF_EN == (O_IO_CLK_EN || O_ADC_CLK_EN);
  endproperty
  a_inbuf: assert property (p_inbuf) else $error("input buffer enable wrong");

  property p_wdt;
    !$past(I_RST) |-> O_WATCHDOG_EN == $past(I_WATCHDOG_ON);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog enable wrong");

  property p_debug;
    !$past(I_RST) |->
      O_DEBUG_EN == ($past(I_DEBUG_FUSE) && $past(I_TEST_PORT_FUSE) && !$past(I_TEST_PORT_DISABLE));
  endproperty
  a_debug: assert property (p_debug) else $error("debug enable wrong");

  property p_debug_osc;
    O_SLEEPING && O_DEBUG_EN |-> O_MAIN_OSC_EN;
  endproperty
  a_debug_osc: assert property (p_debug_osc) else $error("main clock stopped in debug");

  property p_comp;
    O_COMP_OFF |-> O_SLEEPING && !$past(I_COMP_USES_VREF);
  endproperty
  a_comp: assert property (p_comp) else $error("comparator off wrongly");
endmodule // spc_monitor

bind spc_top spc_monitor #(.STARTUP_CYC(STARTUP_CYC)) spc_monitor_i (.*);

// ---- testbench/spc_periph_model.sv ----
`timescale 1ns/100ps
module spc_periph_model (
  // Clock and control
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_clk_en,
  input  wire       i_enable,
  // State
  output reg  [7:0] o_count
);
  // State only moves on the gated clock, so a freeze leaves it intact.
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_count <= 8'h00;
    end else if (i_clk_en && i_enable) begin
      o_count <= o_count + 8'h01;
    end
  end
endmodule // spc_periph_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  localparam [7:0] SU = 8'h03;
  reg        I_CORE_CLK, I_RST, I_CLK_EN, I_IO_SPACE, I_WR, I_RD, I_SLEEP_INSTR;
  reg        I_IRQ_ANY, I_IRQ_NOISE, I_GLOBAL_IE, I_WAKE_PIN, I_T2_ENABLED, I_T2_ASYNC;
  reg        I_T2_OVF, I_T2_CMP, I_EXT_CRYSTAL, I_BROWNOUT_FUSE, I_WATCHDOG_ON;
  reg        I_DEBUG_FUSE, I_TEST_PORT_FUSE, I_TEST_PORT_DISABLE, I_ADC_ENABLE;
  reg        I_ADC_CONV_START, I_COMP_ENABLE, I_COMP_USES_VREF, pen;
  reg  [7:0] I_ADDR, I_WDATA, cnt;
  reg  [1:0] I_T2_IRQ_ENABLES;
  wire [7:0] O_RDATA, O_PERIPH_CLK_EN, O_PERIPH_ACCESS_EN, pcount;
  wire       O_CORE_HALT, O_SLEEPING, O_CPU_CLK_EN, O_FLASH_CLK_EN, O_IO_CLK_EN, O_ADC_CLK_EN;
  wire       O_ASY_CLK_EN, O_MAIN_OSC_EN, O_TIMER_OSC_EN, O_T2_CLK_EN, O_ADC_EN, O_ADC_EXTENDED;
  wire       O_COMP_OFF, O_VREF_EN, O_INPUT_BUF_EN, O_BROWNOUT_EN, O_WATCHDOG_EN, O_DEBUG_EN;
  int        num_errors = 0;
  int        check_count = 0;
  int        tw [8];
  int        n;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};

  spc_top #(.STARTUP_CYC(SU)) spc_top_i (.*);
  spc_periph_model spc_periph_model_i (.i_clk(I_CORE_CLK), .i_rst(I_RST),
    .i_clk_en(O_PERIPH_CLK_EN[0]), .i_enable(pen), .o_count(pcount));

  initial begin
    I_CORE_CLK = 1'b0;
    forever #5 I_CORE_CLK = ~I_CORE_CLK;
  end

  // ********
  // Access and compare tasks.
  // ********
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task acc(input logic io, input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge I_CORE_CLK);
    I_IO_SPACE <= io;
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= w;
    I_RD <= !w;
    @(posedge I_CORE_CLK);
    I_WR <= 1'b0;
    I_RD <= 1'b0;
  endtask

  task rd(input logic io, input logic [7:0] a, input logic [7:0] exp);
    acc(io, a, 8'h00, 1'b0);
    #1 chk(O_RDATA, exp);
  endtask

  task sleep_go(input logic [2:0] c, input logic allow, input logic exp);
    acc(1'b0, 8'h53, {4'h0, c, allow}, 1'b1);
    @(posedge I_CORE_CLK);
    I_SLEEP_INSTR <= 1'b1;
    @(posedge I_CORE_CLK);
    I_SLEEP_INSTR <= 1'b0;
    #1 chk({7'h0, O_SLEEPING}, {7'h0, exp});
  endtask

  // The wait is bounded so a core that never wakes still ends the run.
  task wake(input logic pin, output int k);
    k = 0;
    @(posedge I_CORE_CLK) I_WAKE_PIN <= pin;
    while (O_CORE_HALT !== 1'b0 && k < 300) begin
      @(posedge I_CORE_CLK);
      #1 k++;
    end
    chk({7'h0, O_CORE_HALT}, 8'h00);
    @(posedge I_CORE_CLK) I_WAKE_PIN <= 1'b0;
  endtask

  function automatic [7:0] exp_clk(input [2:0] c);
    case (c)
      3'h0: exp_clk = 8'h1D;
      3'h1: exp_clk = 8'h0D;
      3'h6, 3'h7: exp_clk = 8'h06;
      default: exp_clk = 8'h02;
    endcase
  endfunction

  task results;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    results;
  end

  // ********
  // Test sequence.
  // ********
  initial begin
    {I_CLK_EN, I_RST, I_EXT_CRYSTAL, I_COMP_ENABLE} = 4'hF;
    {I_IO_SPACE, I_WR, I_RD, I_SLEEP_INSTR, I_IRQ_ANY, I_IRQ_NOISE, I_GLOBAL_IE} = 7'h00;
    {I_WAKE_PIN, I_T2_ENABLED, I_T2_ASYNC, I_T2_OVF, I_T2_CMP, I_BROWNOUT_FUSE} = 6'h00;
    {I_WATCHDOG_ON, I_DEBUG_FUSE, I_TEST_PORT_FUSE, I_TEST_PORT_DISABLE} = 4'h0;
    {I_ADC_ENABLE, I_ADC_CONV_START, I_COMP_USES_VREF, pen, I_T2_IRQ_ENABLES} = 6'h00;
    {I_ADDR, I_WDATA} = 16'h0000;
    repeat (2) @(posedge I_CORE_CLK);
    I_RST <= 1'b0;
    @(posedge I_CORE_CLK);
    #1 chk({5'h0, O_CORE_HALT, O_SLEEPING, O_VREF_EN}, 8'h00);
    rd(1'b0, 8'h53, 8'h00);
    acc(1'b0, 8'h53, 8'hFE, 1'b1);
    rd(1'b1, 8'h33, 8'h0E);
    rd(1'b0, 8'h70, 8'h00);
    sleep_go(3'h7, 1'b0, 1'b0);
    $display("registers done");
    foreach (codes[i]) begin
      sleep_go(codes[i], 1'b1, 1'b1);
      chk({1'b0, O_FLASH_CLK_EN, O_CPU_CLK_EN, O_IO_CLK_EN, O_ADC_CLK_EN, O_MAIN_OSC_EN, O_COMP_OFF,
        O_INPUT_BUF_EN}, exp_clk(codes[i]));
      wake(1'b1, tw[codes[i]]);
    end
    for (int c = 4; c < 6; c++) sleep_go(3'(c), 1'b1, 1'b0);
    chk(8'(tw[1] - tw[0]), 8'h00);
    chk(8'(tw[2] - tw[0]), SU);
    chk(8'(tw[3] - tw[2]), 8'h00);
    chk(8'(tw[6] - tw[0]), 8'h06);
    chk(8'(tw[7] - tw[0]), 8'h06);
    $display("modes done");
    @(posedge I_CORE_CLK);
    I_T2_ENABLED <= 1'b1;
    I_T2_IRQ_ENABLES <= 2'b01;
    sleep_go(3'h3, 1'b1, 1'b1);
    chk({4'h0, O_MAIN_OSC_EN, O_TIMER_OSC_EN, O_T2_CLK_EN, O_ASY_CLK_EN}, 8'h0A);
    @(posedge I_CORE_CLK) I_T2_OVF <= 1'b1;
    repeat (8) @(posedge I_CORE_CLK);
    #1 chk({7'h0, O_SLEEPING}, 8'h01);
    @(posedge I_CORE_CLK) I_GLOBAL_IE <= 1'b1;
    wake(1'b0, n);
    I_T2_OVF <= 1'b0;
    I_T2_ASYNC <= 1'b1;
    I_T2_IRQ_ENABLES <= 2'b10;
    sleep_go(3'h3, 1'b1, 1'b1);
    chk({4'h0, O_MAIN_OSC_EN, O_TIMER_OSC_EN, O_T2_CLK_EN, O_ASY_CLK_EN}, 8'h07);
    @(posedge I_CORE_CLK) I_T2_CMP <= 1'b1;
    wake(1'b0, n);
    I_T2_CMP <= 1'b0;
    I_T2_ENABLED <= 1'b0;
    $display("timer2 done");
    @(posedge I_CORE_CLK) I_ADC_ENABLE <= 1'b1;
    repeat (2) @(posedge I_CORE_CLK);
    #1 chk({6'h0, O_ADC_EXTENDED, O_VREF_EN}, 8'h03);
    @(posedge I_CORE_CLK) I_ADC_CONV_START <= 1'b1;
    @(posedge I_CORE_CLK) I_ADC_CONV_START <= 1'b0;
    #1 chk({7'h0, O_ADC_EXTENDED}, 8'h00);
    @(posedge I_CORE_CLK);
    {I_BROWNOUT_FUSE, I_WATCHDOG_ON, I_DEBUG_FUSE, I_TEST_PORT_FUSE} <= 4'hF;
    sleep_go(3'h2, 1'b1, 1'b1);
    chk({3'h0, O_ADC_EN, O_BROWNOUT_EN, O_WATCHDOG_EN, O_MAIN_OSC_EN, O_VREF_EN},
      8'h1F);
    wake(1'b1, n);
    I_ADC_ENABLE <= 1'b0;
    I_TEST_PORT_DISABLE <= 1'b1;
    @(posedge I_CORE_CLK) I_ADC_ENABLE <= 1'b1;
    repeat (2) @(posedge I_CORE_CLK);
    #1 chk({6'h0, O_ADC_EXTENDED, O_DEBUG_EN}, 8'h02);
    @(posedge I_CORE_CLK);
    {I_BROWNOUT_FUSE, I_ADC_ENABLE, I_COMP_USES_VREF} <= 3'b001;
    sleep_go(3'h2, 1'b1, 1'b1);
    chk({5'h0, O_COMP_OFF, O_VREF_EN, O_MAIN_OSC_EN}, 8'h02);
    wake(1'b1, n);
    I_COMP_USES_VREF <= 1'b0;
    repeat (2) @(posedge I_CORE_CLK);
    #1 chk({7'h0, O_VREF_EN}, 8'h00);
    $display("analog done");
    @(posedge I_CORE_CLK) pen <= 1'b0;
    acc(1'b0, 8'h64, 8'h01, 1'b1);
    rd(1'b0, 8'h64, 8'h01);
    rd(1'b1, 8'h44, 8'h00);
    chk({6'h0, O_PERIPH_CLK_EN[0], O_PERIPH_ACCESS_EN[0]}, 8'h00);
    cnt = pcount;
    @(posedge I_CORE_CLK) pen <= 1'b1;
    repeat (5) @(posedge I_CORE_CLK);
    #1 chk(pcount, cnt);
    acc(1'b0, 8'h64, 8'h00, 1'b1);
    n = 0;
    while (O_PERIPH_CLK_EN[0] !== 1'b1 && n < 10) begin
      @(posedge I_CORE_CLK);
      #1 n++;
    end
    repeat (3) @(posedge I_CORE_CLK);
    #1 chk(pcount, cnt + 8'h03);
    $display("gating done");
    results;
  end
endmodule // tb_top
